// file: rcsa_run_command_arbiter.sv
// top level of the run command source arbiter with its register port
// Overview of operation
// - source 2: run terminal requests run, direction terminal high means reverse
// - each of seven terminals can be given run (1) or direction (2) function
// - source 3: run and direction come from the serial link host commands
// - key function value 2 enables local/remote switching by the mode key
// - enabling key switching puts the device in remote at once, nothing else changes
// - press in remote goes local, indicator flashes, keypad run key only
// - press in local goes remote, indicator off, configured source governs again
// - local jog works only while a run-permit (13) terminal is active
// - remote mode follows the configured command source
// - with power-on run off, active terminals at power-on start nothing
// - terminal run accepted only after start terminals seen off then on
// - after a fault reset during run, start in local with keypad control
// - then local-to-remote stops; terminals wait until all are seen off
// - remote-to-local while running stops the drive
// - local-to-remote with terminal source keeps running per terminals
// - local-to-remote with keypad or serial source stops until next command
// - source 1: both terminals on or both off means stop
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ns
module rcsa_run_command_arbiter
   import rcsa_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYCLES_DFLT,
   parameter int FLASH_CYCLES    = FLASH_CYCLES_DFLT
) (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   input  wire logic [TERM_N-1:0] term_pin_i,
   input  wire logic              mode_key_pin_i,
   input  wire logic              run_key_pin_i,
   input  wire logic              stop_key_pin_i,
   input  wire logic              jog_key_pin_i,
   input  wire logic              fault_restart_i,
   input  wire logic              serial_valid_i,
   input  wire logic              serial_run_i,
   input  wire logic              serial_rev_i,
   output logic                   run_o,
   output logic                   reverse_o,
   output logic                   jog_o,
   output logic                   local_mode_o,
   output logic                   mode_led_o
);
   localparam int FL_W = $clog2(FLASH_CYCLES + 1);

   // configuration state
   logic [SRC_W-1:0]  cmd_src, next_cmd_src;
   logic [KFN_W-1:0]  key_fn, next_key_fn;
   logic              power_on_run, next_power_on_run;
   rcsa_func_arr_t    term_func, next_term_func;
   logic [DATA_W-1:0] next_rdata;
   // control state
   logic              in_local, next_local;
   logic              post_fault, next_post_fault;
   logic              wait_clear, next_wait_clear;
   logic              key_run, next_key_run;
   logic              ser_run, next_ser_run;
   logic              ser_rev, next_ser_rev;
   logic [TERM_N-1:0] term_ok, next_term_ok;
   logic [1:0]        start_cnt, next_start_cnt;
   logic [KFN_W-1:0]  key_fn_prev;
   logic              next_run, next_rev, next_jog;
   logic [FL_W-1:0]   flash_cnt, next_flash_cnt;
   logic              phase, next_phase, next_led;
   // synchronisers and decode
   logic [TERM_N-1:0] term_meta, term_sync;
   logic [1:0]        misc_meta, misc_sync;
   logic [KEY_N-1:0]  press;
   logic [TERM_N-1:0] run_mask, dir_mask, permit_mask, start_mask, term_eff;
   logic              fx, rx, permit, jog_sync, fault_sync;
   logic              mode_press, to_local, to_remote, lr_enable_edge, src_is_term;
   logic [TI_W:0]     wr_slot, rd_slot;
   logic [DATA_W-1:0] status_word;

   // mask of terminals assigned one function code
   function automatic logic [TERM_N-1:0] term_mask(input rcsa_func_arr_t f,
                                                   input logic [FUNC_W-1:0] code);
      logic [TERM_N-1:0] m;
      m = '0;
      for (int i = 0; i < TERM_N; i++) begin
         m[i] = (f[i] == code);
      end
      return m;
   endfunction

   // hit flag and index of a terminal function register address
   function automatic logic [TI_W:0] term_slot(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = a - REG_TERM_FUNC_BASE;
      if (a >= REG_TERM_FUNC_BASE && off[1:0] == 2'h0
          && off[ADDR_W-1:2] < (ADDR_W-2)'(TERM_N)) begin
         return {1'b1, off[TI_W+1:2]};
      end
      return '0;
   endfunction

   // pins cross into the clock domain through two flops each
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         term_meta <= '0;
         term_sync <= '0;
         misc_meta <= '0;
         misc_sync <= '0;
      end else begin
         term_meta <= term_pin_i;
         term_sync <= term_meta;
         misc_meta <= {fault_restart_i, jog_key_pin_i};
         misc_sync <= misc_meta;
      end
   end
   assign jog_sync   = misc_sync[0];
   assign fault_sync = misc_sync[1];

   // debounced keypad keys
   genvar k;
   generate
      for (k = 0; k < KEY_N; k++) begin : g_key
         rcsa_key_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_deb (
            .clk_i     (clk_i),
            .reset_i   (reset_i),
            .key_pin_i ((k == KEY_MODE) ? mode_key_pin_i :
                        (k == KEY_RUN)  ? run_key_pin_i : stop_key_pin_i),
            .press_o   (press[k])
         );
      end
   endgenerate

   // terminal roles from their function codes
   assign run_mask    = term_mask(term_func, FN_RUN);
   assign dir_mask    = term_mask(term_func, FN_DIR);
   assign permit_mask = term_mask(term_func, FN_RUN_PERMIT);
   assign start_mask  = run_mask | dir_mask | term_mask(term_func, FN_JOG_FWD)
                      | term_mask(term_func, FN_JOG_REV) | term_mask(term_func, FN_PRE_EXC);
   // start terminals count only once armed
   assign term_eff    = term_sync & (term_ok | ~start_mask);
   assign fx          = |(term_eff & run_mask);
   assign rx          = |(term_eff & dir_mask);
   assign permit      = |(term_sync & permit_mask);
   assign src_is_term = (cmd_src == SRC_PAIR) || (cmd_src == SRC_RUN_DIR);

   // mode key honoured when enabled, or to leave post-fault local
   assign mode_press = press[KEY_MODE] && (start_cnt == START_CAPTURE)
                       && (key_fn == KEY_FN_LOCAL_REMOTE || post_fault);
   assign to_local   = mode_press && !in_local;
   assign to_remote  = mode_press && in_local;
   assign lr_enable_edge = (key_fn == KEY_FN_LOCAL_REMOTE) && (key_fn_prev != key_fn);

   assign wr_slot = term_slot(addr_i);
   assign rd_slot = wr_slot;

   // status word, unused bits read zero
   always_comb begin
      status_word           = '0;
      status_word[ST_LOCAL] = in_local;
      status_word[ST_RUN]   = run_o;
      status_word[ST_REV]   = reverse_o;
      status_word[ST_JOG]   = jog_o;
      status_word[ST_ARMED] = &term_ok;
      status_word[ST_FAULT] = post_fault;
      status_word[ST_WAIT]  = wait_clear;
   end

   // register writes and reads; read data stands one cycle only
   always_comb begin
      next_cmd_src      = cmd_src;
      next_key_fn       = key_fn;
      next_power_on_run = power_on_run;
      next_term_func    = term_func;
      next_rdata        = '0;
      if (wr_i) begin
         if (addr_i == REG_CMD_SOURCE) begin
            next_cmd_src = wdata_i[SRC_W-1:0];
         end else if (addr_i == REG_KEY_FUNC) begin
            next_key_fn = wdata_i[KFN_W-1:0];
         end else if (addr_i == REG_POWER_ON_RUN) begin
            next_power_on_run = wdata_i[0];
         end else if (wr_slot[TI_W]) begin
            next_term_func[wr_slot[TI_W-1:0]] = wdata_i[FUNC_W-1:0];
         end
      end
      if (rd_i) begin
         if (addr_i == REG_CMD_SOURCE) begin
            next_rdata[SRC_W-1:0] = cmd_src;
         end else if (addr_i == REG_KEY_FUNC) begin
            next_rdata[KFN_W-1:0] = key_fn;
         end else if (addr_i == REG_POWER_ON_RUN) begin
            next_rdata[0] = power_on_run;
         end else if (addr_i == REG_STATUS) begin
            next_rdata = status_word;
         end else if (rd_slot[TI_W]) begin
            next_rdata[FUNC_W-1:0] = term_func[rd_slot[TI_W-1:0]];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cmd_src      <= CMD_SOURCE_RST;
         key_fn       <= KEY_FUNC_RST;
         power_on_run <= POWER_ON_RUN_RST;
         term_func    <= {TERM_N{TERM_FUNC_RST}};
         rdata_o      <= '0;
      end else begin
         cmd_src      <= next_cmd_src;
         key_fn       <= next_key_fn;
         power_on_run <= next_power_on_run;
         term_func    <= next_term_func;
         rdata_o      <= next_rdata;
      end
   end

   // mode switching, command latches and terminal arming
   always_comb begin
      next_local      = in_local;
      next_post_fault = post_fault;
      next_wait_clear = wait_clear;
      next_key_run    = key_run;
      next_ser_run    = ser_run;
      next_ser_rev    = ser_rev;
      next_start_cnt  = start_cnt;
      // arm each terminal once it is seen inactive; the sync's reset zeros
      // are no real release, so wait until it carries pin values
      next_term_ok    = term_ok;
      if (start_cnt >= START_CAPTURE - 2'h1) begin
         next_term_ok = term_ok | ~term_sync;
      end
      // power-on run setting arms every terminal at once
      if (power_on_run) begin
         next_term_ok = '1;
      end
      if (start_cnt != START_CAPTURE) begin
         next_start_cnt = start_cnt + 2'h1;
      end
      if (wait_clear && term_sync == '0) begin
         next_wait_clear = 1'b0;
      end
      // going local drops the keypad run request
      if (to_local) begin
         next_local   = 1'b1;
         next_key_run = 1'b0;
      end else if (to_remote) begin
         next_local = 1'b0;
         // terminal sources latch nothing, so they resume per the pins
         // post-fault return to remote stops and waits for release
         if (post_fault) begin
            next_post_fault = 1'b0;
            next_wait_clear = 1'b1;
            next_key_run    = 1'b0;
         // digital sources stop until their next command
         end else if (!src_is_term) begin
            next_key_run = 1'b0;
            next_ser_run = 1'b0;
         end
      end
      // enabling the key function lands in remote
      if (lr_enable_edge) begin
         next_local = 1'b0;
      end
      // fault-reset level caught after release selects local
      if (start_cnt == START_CAPTURE - 2'h1) begin
         next_local      = fault_sync;
         next_post_fault = fault_sync;
      end
      // keypad keys act in local or with keypad source; stop wins
      if (next_local || cmd_src == SRC_KEYPAD) begin
         if (press[KEY_RUN]) begin
            next_key_run = 1'b1;
         end
         if (press[KEY_STOP]) begin
            next_key_run = 1'b0;
         end
      end
      // serial commands load only in remote with serial source
      if (serial_valid_i && cmd_src == SRC_SERIAL && !next_local) begin
         next_ser_run = serial_run_i;
         next_ser_rev = serial_rev_i;
      end
   end

   // command selection by mode and source
   always_comb begin
      next_run = 1'b0;
      next_rev = 1'b0;
      if (in_local) begin
         next_run = key_run;
      end else begin
         case (cmd_src)
            SRC_KEYPAD: next_run = key_run;
            // both on or both off gives stop
            SRC_PAIR: begin
               next_run = (fx ^ rx) && !wait_clear;
               next_rev = rx && !fx;
            end
            SRC_RUN_DIR: begin
               next_run = fx && !wait_clear;
               next_rev = rx;
            end
            SRC_SERIAL: begin
               next_run = ser_run;
               next_rev = ser_rev;
            end
            default: next_run = 1'b0;
         endcase
      end
      // local jog needs an active run-permit terminal
      next_jog = in_local && permit && jog_sync;
   end

   // indicator flash divider; restarts lit each time local begins
   always_comb begin
      next_flash_cnt = flash_cnt + FL_W'(1);
      next_phase     = phase;
      if (flash_cnt == FL_W'(FLASH_CYCLES - 1)) begin
         next_flash_cnt = '0;
         next_phase     = !phase;
      end
      if (!in_local) begin
         next_flash_cnt = '0;
         next_phase     = 1'b1;
      end
      next_led = in_local && phase;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         in_local    <= 1'b0;
         post_fault  <= 1'b0;
         wait_clear  <= 1'b0;
         key_run     <= 1'b0;
         ser_run     <= 1'b0;
         ser_rev     <= 1'b0;
         term_ok     <= '0;
         start_cnt   <= 2'h0;
         key_fn_prev <= KEY_FUNC_RST;
         run_o       <= 1'b0;
         reverse_o   <= 1'b0;
         jog_o       <= 1'b0;
         flash_cnt   <= '0;
         phase       <= 1'b1;
         mode_led_o  <= 1'b0;
      end else begin
         in_local    <= next_local;
         post_fault  <= next_post_fault;
         wait_clear  <= next_wait_clear;
         key_run     <= next_key_run;
         ser_run     <= next_ser_run;
         ser_rev     <= next_ser_rev;
         term_ok     <= next_term_ok;
         start_cnt   <= next_start_cnt;
         key_fn_prev <= key_fn;
         run_o       <= next_run;
         reverse_o   <= next_rev;
         jog_o       <= next_jog;
         flash_cnt   <= next_flash_cnt;
         phase       <= next_phase;
         mode_led_o  <= next_led;
      end
   end
   assign local_mode_o = in_local;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   chk_rundir_decode: assert property (!in_local && cmd_src == SRC_RUN_DIR |=>
      reverse_o == $past(rx) && run_o == $past(fx && !wait_clear))
      else $error("run plus direction decode wrong");
   chk_pair_stop: assert property (!in_local && cmd_src == SRC_PAIR && fx == rx
      |=> !run_o)
      else $error("pair mode did not stop on equal terminals");
   chk_serial_load: assert property (serial_valid_i && cmd_src == SRC_SERIAL && !next_local
      |=> ser_run == $past(serial_run_i) && ser_rev == $past(serial_rev_i))
      else $error("serial command not taken");
   chk_local_key_only: assert property (in_local |=> run_o == $past(key_run) && !reverse_o)
      else $error("local mode run not from keypad");
   chk_remote_led_off: assert property (!in_local |=> !mode_led_o)
      else $error("indicator lit in remote mode");
   chk_enable_remote: assert property (lr_enable_edge && start_cnt == START_CAPTURE
      |=> !in_local)
      else $error("enabling key switching did not enter remote");
   chk_local_stop: assert property (to_local && !press[KEY_RUN] |=> ##1 !run_o)
      else $error("drive kept running after going local");
   chk_jog_permit: assert property (jog_o |-> $past(in_local && permit && jog_sync))
      else $error("jog without run permit in local mode");
   chk_arm_on_release: assert property (!$past(power_on_run) |->
      ((term_ok & ~$past(term_ok)) & $past(term_sync)) == '0)
      else $error("terminal armed while still active");
   chk_fault_start: assert property (start_cnt == START_CAPTURE - 2'h1 |=>
      in_local == $past(fault_sync) && post_fault == $past(fault_sync))
      else $error("post-fault start mode wrong");
   chk_fault_wait: assert property (to_remote && post_fault |=> wait_clear && !key_run)
      else $error("post-fault return to remote did not stop");
   chk_digital_stop: assert property (to_remote && !post_fault && !src_is_term
      && !press[KEY_RUN] && !serial_valid_i |=> !key_run && !ser_run)
      else $error("digital source kept running after going remote");

   cov_local_round_trip: cover property (to_local ##[1:200] to_remote);
   cov_serial_run: cover property (!in_local && cmd_src == SRC_SERIAL ##1 run_o);
   cov_pair_reverse: cover property (!in_local && cmd_src == SRC_PAIR ##1 run_o && reverse_o);
   cov_local_jog: cover property (jog_o);
endmodule

// file: rcsa_pkg.sv
// constants and types shared by the run command source arbiter files
package rcsa_pkg;
   // terminal block shape
   localparam int TERM_N = 7;
   localparam int FUNC_W = 6;
   localparam int TI_W   = 3;
   localparam int SRC_W  = 3;
   localparam int KFN_W  = 2;

   // register port shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // command source settings
   localparam logic [SRC_W-1:0] SRC_KEYPAD  = 3'h0;
   localparam logic [SRC_W-1:0] SRC_PAIR    = 3'h1;
   localparam logic [SRC_W-1:0] SRC_RUN_DIR = 3'h2;
   localparam logic [SRC_W-1:0] SRC_SERIAL  = 3'h3;

   // terminal function codes
   localparam logic [FUNC_W-1:0] FN_RUN        = 6'h01;
   localparam logic [FUNC_W-1:0] FN_DIR        = 6'h02;
   localparam logic [FUNC_W-1:0] FN_RUN_PERMIT = 6'h0D;
   localparam logic [FUNC_W-1:0] FN_JOG_FWD    = 6'h0E;
   localparam logic [FUNC_W-1:0] FN_JOG_REV    = 6'h0F;
   localparam logic [FUNC_W-1:0] FN_PRE_EXC    = 6'h10;

   // programmable key function
   localparam logic [KFN_W-1:0] KEY_FN_LOCAL_REMOTE = 2'h2;

   // register byte addresses
   localparam logic [ADDR_W-1:0] REG_CMD_SOURCE     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_KEY_FUNC       = 8'h04;
   localparam logic [ADDR_W-1:0] REG_POWER_ON_RUN   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_STATUS         = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_TERM_FUNC_BASE = 8'h10;

   // reset values
   localparam logic [SRC_W-1:0]  CMD_SOURCE_RST   = 3'h0;
   localparam logic [KFN_W-1:0]  KEY_FUNC_RST     = 2'h0;
   localparam logic              POWER_ON_RUN_RST = 1'b0;
   localparam logic [FUNC_W-1:0] TERM_FUNC_RST    = 6'h00;

   // status bit positions
   localparam int ST_LOCAL = 0;
   localparam int ST_RUN   = 1;
   localparam int ST_REV   = 2;
   localparam int ST_JOG   = 3;
   localparam int ST_ARMED = 4;
   localparam int ST_FAULT = 5;
   localparam int ST_WAIT  = 6;

   // keypad key slots
   localparam int KEY_N    = 3;
   localparam int KEY_MODE = 0;
   localparam int KEY_RUN  = 1;
   localparam int KEY_STOP = 2;

   // timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int DEBOUNCE_MS  = 10;
   localparam int FLASH_MS     = 250;
   localparam int DEBOUNCE_CYCLES_DFLT = CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int FLASH_CYCLES_DFLT    = CLK_HZ / 1000 * FLASH_MS;
   localparam logic [1:0] START_CAPTURE = 2'h3;

   typedef logic [TERM_N-1:0][FUNC_W-1:0] rcsa_func_arr_t;
endpackage

// file: rcsa_key_debounce.sv
// keypad key synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ns
module rcsa_key_debounce #(
   parameter int STABLE_CYCLES = 1000
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic key_pin_i,
   output logic      press_o
);
   localparam int CW = $clog2(STABLE_CYCLES + 1);

   logic          key_meta;
   logic          key_sync;
   logic          stable;
   logic          next_stable;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          next_press;

   // two flops before anything looks at the pin
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         key_meta <= 1'b0;
         key_sync <= 1'b0;
      end else begin
         key_meta <= key_pin_i;
         key_sync <= key_meta;
      end
   end

   // accept a level only once it held for the full window
   always_comb begin
      next_cnt    = '0;
      next_stable = stable;
      next_press  = 1'b0;
      if (key_sync != stable) begin
         next_cnt = cnt + CW'(1);
         if (cnt == CW'(STABLE_CYCLES - 1)) begin
            next_cnt    = '0;
            next_stable = key_sync;
            next_press  = key_sync;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cnt     <= '0;
         stable  <= 1'b0;
         press_o <= 1'b0;
      end else begin
         cnt     <= next_cnt;
         stable  <= next_stable;
         press_o <= next_press;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   chk_press_single_pulse: assert property (press_o |=> !press_o)
      else $error("key press pulse longer than one cycle");
   chk_press_after_stable: assert property (press_o |-> $past(stable) == 1'b0 && stable)
      else $error("key press without a stable rising level");
endmodule

// file: rcsa_host_model.sv
// host controller and terminal block stand-in for the arbiter bench
`timescale 1ns/1ns
module rcsa_host_model
   import rcsa_pkg::*;
(
   input  wire logic              clk_i,
   output logic      [TERM_N-1:0] term_pin_o,
   output logic                   serial_valid_o,
   output logic                   serial_run_o,
   output logic                   serial_rev_o
);
   // terminals start active so power-on behaviour is exercised
   initial begin
      term_pin_o = 7'h7F;
      serial_valid_o = 1'b0;
      serial_run_o = 1'b0;
      serial_rev_o = 1'b1;
   end
   task automatic set_terms(input logic [TERM_N-1:0] v);
      @(posedge clk_i);
      term_pin_o <= v;
   endtask
   task automatic send(input logic r, input logic d);
      @(posedge clk_i);
      serial_valid_o <= 1'b1;
      serial_run_o <= r;
      serial_rev_o <= d;
      @(posedge clk_i);
      serial_valid_o <= 1'b0;
      serial_run_o <= ~r; // inverted so a stale bit never passes
      serial_rev_o <= ~d;
   endtask
endmodule

// file: run_command_source_arbiter_bench.sv
// self-checking bench for the run command source arbiter
`timescale 1ns/1ns
module run_command_source_arbiter_bench
   import rcsa_pkg::*;
   ;
   logic                clk = 1'b0;
   logic                reset = 1'b1;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wdata;
   logic                wr;
   logic                rd;
   logic                rd_d = 1'b0;
   logic [DATA_W-1:0]   rdata;
   logic [3:0]          keys; // mode, run, stop, jog
   logic                fault;
   logic [TERM_N-1:0]   terms;
   logic                s_valid, s_run, s_rev, run, rev, jog, loc, led, loc_d, led_d;
   int                  flips = 0;
   logic [15:0]         lfsr = 16'hF52B;
   logic [2*DATA_W-1:0] notes[$]; // mask above, expected below
   int                  bad_count = 0;
   int                  tests_run = 0;
   // slow counts shortened so the run stays brief
   rcsa_run_command_arbiter #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8)) dut_u (
      .clk_i(clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
      .rdata_o(rdata), .term_pin_i(terms), .mode_key_pin_i(keys[KEY_MODE]),
      .run_key_pin_i(keys[KEY_RUN]), .stop_key_pin_i(keys[KEY_STOP]), .jog_key_pin_i(keys[3]),
      .fault_restart_i(fault), .serial_valid_i(s_valid), .serial_run_i(s_run),
      .serial_rev_i(s_rev), .run_o(run), .reverse_o(rev), .jog_o(jog),
      .local_mode_o(loc), .mode_led_o(led));
   rcsa_host_model host_u (.clk_i(clk), .term_pin_o(terms), .serial_valid_o(s_valid),
      .serial_run_o(s_run), .serial_rev_o(s_rev));
   always #5 clk = ~clk;
   function automatic logic [15:0] next_rand();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   function automatic logic [DATA_W-1:0] st(input logic l, input logic r, input logic v);
      return (DATA_W'(l) << ST_LOCAL) | (DATA_W'(r) << ST_RUN) | (DATA_W'(v) << ST_REV);
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // the expectation is noted before the strobe goes out
   task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                         input logic [DATA_W-1:0] m);
      notes.push_back({m, e});
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // hold well past debounce so exactly one press registers
   task automatic press(input int k);
      @(posedge clk);
      keys[k] <= 1'b1;
      wt(12);
      keys[k] <= 1'b0;
      wt(12);
   endtask
   task automatic done(input string s);
      wt(3);
      $display("test done: %s", s);
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) begin
         check(rdata & notes[0][63:32], notes[0][31:0]);
         void'(notes.pop_front());
      end
      // indicator dark in settled remote; flips counted in local
      if (!loc && !loc_d) check(DATA_W'(led), '0);
      if (loc && led != led_d) flips <= flips + 1;
      loc_d <= loc;
      led_d <= led;
      rd_d <= rd;
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // a hang far beyond the expected few hundred cycles ends the run
   initial begin
      wt(20000);
      bad_count++;
      summarize();
   end
   initial begin
      {addr, wdata, keys, wr, rd, fault} <= '0;
      wt(10);
      reset <= 1'b0;
      wt(6);
      rd_reg(REG_CMD_SOURCE, '0, '1);
      rd_reg(REG_KEY_FUNC, '0, '1);
      rd_reg(REG_POWER_ON_RUN, '0, '1);
      rd_reg(8'h40, '0, '1);
      wr_reg(REG_TERM_FUNC_BASE, {26'h0, FN_RUN});
      wr_reg(REG_TERM_FUNC_BASE + 8'h04, {26'h0, FN_DIR});
      wr_reg(REG_TERM_FUNC_BASE + 8'h08, {26'h0, FN_RUN_PERMIT});
      wr_reg(REG_CMD_SOURCE, {next_rand(), 13'h0, SRC_RUN_DIR});
      rd_reg(REG_CMD_SOURCE, {29'h0, SRC_RUN_DIR}, '1);
      wt(6);
      rd_reg(REG_STATUS, st(0, 0, 0), st(1, 1, 1));
      host_u.set_terms(7'h00);
      wt(6);
      host_u.set_terms(7'h03);
      wt(6);
      rd_reg(REG_STATUS, st(0, 1, 1), st(1, 1, 1));
      host_u.set_terms(7'h01);
      wt(6);
      rd_reg(REG_STATUS, st(0, 1, 0), st(1, 1, 1));
      done("terminal run and direction");
      wr_reg(REG_CMD_SOURCE, {29'h0, SRC_PAIR});
      host_u.set_terms(7'h03);
      wt(6);
      rd_reg(REG_STATUS, st(0, 0, 0), st(0, 1, 0));
      host_u.set_terms(7'h02);
      wt(6);
      rd_reg(REG_STATUS, st(0, 1, 1), st(1, 1, 1));
      host_u.set_terms(7'h01);
      done("forward reverse pair");
      wr_reg(REG_CMD_SOURCE, {29'h0, SRC_SERIAL});
      host_u.send(1'b1, 1'b1);
      wt(4);
      rd_reg(REG_STATUS, st(0, 1, 1), st(1, 1, 1));
      host_u.send(1'b1, 1'b0);
      wt(4);
      rd_reg(REG_STATUS, st(0, 1, 0), st(1, 1, 1));
      done("serial source");
      wr_reg(REG_KEY_FUNC, {30'h0, KEY_FN_LOCAL_REMOTE});
      wt(3);
      rd_reg(REG_STATUS, st(0, 1, 0), st(1, 1, 1));
      press(KEY_MODE);
      rd_reg(REG_STATUS, st(1, 0, 0), st(1, 1, 0));
      keys[3] <= 1'b1;
      wt(6);
      rd_reg(REG_STATUS, '0, DATA_W'(1) << ST_JOG);
      host_u.set_terms(7'h05);
      wt(6);
      rd_reg(REG_STATUS, DATA_W'(1) << ST_JOG, DATA_W'(1) << ST_JOG);
      keys[3] <= 1'b0;
      press(KEY_RUN);
      rd_reg(REG_STATUS, st(1, 1, 0), st(1, 1, 0));
      check(DATA_W'({loc, flips != 0}), 32'h3);
      press(KEY_STOP);
      rd_reg(REG_STATUS, st(1, 0, 0), st(1, 1, 0));
      press(KEY_MODE);
      rd_reg(REG_STATUS, st(0, 0, 0), st(1, 1, 0));
      done("local and remote switching");
      wr_reg(REG_CMD_SOURCE, {29'h0, SRC_RUN_DIR});
      host_u.set_terms(7'h03);
      wt(6);
      press(KEY_MODE);
      rd_reg(REG_STATUS, st(1, 0, 0), st(1, 1, 0));
      press(KEY_MODE);
      rd_reg(REG_STATUS, st(0, 1, 1), st(1, 1, 1));
      done("terminal source across switch");
      fault <= 1'b1;
      reset <= 1'b1;
      wt(10);
      reset <= 1'b0;
      wt(8);
      rd_reg(REG_STATUS, st(1, 0, 0), st(1, 0, 0));
      wr_reg(REG_TERM_FUNC_BASE, {26'h0, FN_RUN});
      wr_reg(REG_CMD_SOURCE, {29'h0, SRC_RUN_DIR});
      host_u.set_terms(7'h01);
      press(KEY_RUN);
      rd_reg(REG_STATUS, st(1, 1, 0), st(1, 1, 0));
      press(KEY_MODE);
      rd_reg(REG_STATUS, st(0, 0, 0), st(1, 1, 0));
      host_u.set_terms(7'h00);
      wt(6);
      host_u.set_terms(7'h01);
      wt(6);
      rd_reg(REG_STATUS, st(0, 1, 0), st(1, 1, 0));
      done("restart after fault");
      summarize();
   end
endmodule
